// [hdl/lls_defs.svh]
`ifndef LLS_DEFS_SVH
`define LLS_DEFS_SVH
`define LLS_CLK_MHZ        20
`define LLS_TICK_US        10
`define LLS_TICK_CYC       (`LLS_CLK_MHZ * `LLS_TICK_US)
`define LLS_GAP_MS         5
`define LLS_GAP_TICKS      ((`LLS_GAP_MS * 1000) / `LLS_TICK_US)
`define LLS_STEP_MIN_TICKS 34'h000000001
`define LLS_STEP_MAX_TICKS 34'h2540be3ff
`define LLS_NUM_LISTS      7
`define LLS_NUM_STEPS      50
`define LLS_ZERO_LEVEL     16'h0000
`define LLS_ONE_STEP       6'h01
`define LLS_ONE_LIST       3'h1
`endif

// [hdl/lls_pkg.sv]
package lls_pkg;
  // regulation modes of one step
  typedef enum logic [1:0]
  {
    LLS_MODE_CC = 2'h0,
    LLS_MODE_CV = 2'h1,
    LLS_MODE_CR = 2'h2
  } lls_mode_t;

  // overall operation selected by the user
  typedef enum logic [2:0]
  {
    LLS_OP_BASIC   = 3'h0,
    LLS_OP_TRAN    = 3'h1,
    LLS_OP_LIST    = 3'h2,
    LLS_OP_BATTERY = 3'h3
  } lls_op_t;

  typedef enum logic [1:0]
  {
    LLS_TRAN_CONT   = 2'h0,
    LLS_TRAN_PULSE  = 2'h1,
    LLS_TRAN_TOGGLE = 2'h2
  } lls_tran_t;

  typedef enum logic [1:0]
  {
    LLS_SRC_BUS  = 2'h0,
    LLS_SRC_EXT  = 2'h1,
    LLS_SRC_HOLD = 2'h2
  } lls_src_t;

  // one stored list step
  typedef struct packed
  {
    lls_mode_t   mode;
    logic [15:0] value;
    logic [33:0] ticks;
  } lls_step_t;

  // per-list settings
  typedef struct packed
  {
    logic [5:0]  length;
    logic [15:0] cycles;
    logic        chain_en;
    logic [2:0]  chain_to;
  } lls_list_t;

  // step-write port
  typedef struct packed
  {
    logic        wr;
    logic [2:0]  list;
    logic [5:0]  index;
    lls_step_t   step;
  } lls_step_wr_t;
endpackage

// [hdl/lls_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
`include "lls_defs.svh"

// Behaviour
// - step durations span 10 us to 99999.99999 s on a wide tick timer.
// - each step holds its own mode, load value and duration.
// - seven lists of up to fifty steps are stored.
// - a list repeats from step one for a programmed cycle count.
// - a finished list chained to another starts that list automatically.
// - mode change between steps forces input off for a 5 ms gap.
// - input cut by turn-on threshold or current limit aborts the list run.
// - constant-current battery discharge stops when voltage reaches cut-off.
// - short-circuit flag changes nothing stored; value follows active mode.
// - trigger copies pending presets to immediate levels.
// - toggle mode swaps low/high per trigger; pulse mode fires one pulse.
// - in list operation a trigger starts the selected list.
// - bus source accepts group-execute-trigger, *TRG or the immediate trigger command.
// - external source uses falling edge of trigger pin or front key.
// - hold source accepts only the immediate trigger command.
// - immediate trigger works in every source; source set only remotely.
// - input on/off keeps settings; off forces zero current.
// - local operation changes refused while input is on.
// - input starts conducting only with voltage at or above turn-on threshold.
// - with hold enabled input stays on once threshold reached.
// - without hold input follows threshold both ways.
// - constant voltage falls back to constant current at the current cap.
// - pulse triggers ignored unless the pulse is at low level.
module lls_sequencer
(
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire lls_pkg::lls_step_wr_t step_wr,
  input  wire logic                  list_wr,
  input  wire logic [2:0]            list_wr_sel,
  input  wire lls_pkg::lls_list_t    list_wr_data,
  input  wire logic [2:0]            list_select,
  input  wire logic                  remote_ctl,
  input  wire logic                  op_req,
  input  wire lls_pkg::lls_op_t      op_req_val,
  input  wire lls_pkg::lls_mode_t    basic_mode,
  input  wire lls_pkg::lls_tran_t    tran_mode,
  input  wire logic                  src_wr,
  input  wire lls_pkg::lls_src_t     src_wr_val,
  input  wire logic                  bus_get,
  input  wire logic                  bus_trg_cmd,
  input  wire logic                  trig_imm_cmd,
  input  wire logic                  ext_trig_in,
  input  wire logic                  key_trig,
  input  wire logic                  pulse_busy,
  input  wire logic [15:0]           preset_cc,
  input  wire logic [15:0]           preset_cv,
  input  wire logic [15:0]           preset_cr,
  input  wire logic                  input_on_cmd,
  input  wire logic                  input_off_cmd,
  input  wire logic                  von_ok,
  input  wire logic                  von_latch_en,
  input  wire logic                  curr_limit_trip,
  input  wire logic                  cv_cap_reached,
  input  wire logic                  batt_at_cutoff,
  input  wire logic                  short_en,
  output lls_pkg::lls_op_t           op_active,
  output lls_pkg::lls_src_t          trig_src,
  output lls_pkg::lls_mode_t         reg_mode,
  output logic [15:0]                reg_value,
  output logic [15:0]                imm_cc,
  output logic [15:0]                imm_cv,
  output logic [15:0]                imm_cr,
  output logic                       short_active,
  output logic                       conduct,
  output logic                       input_on,
  output logic                       tran_high,
  output logic                       pulse_fire,
  output logic                       list_running,
  output logic                       list_in_gap,
  output logic [2:0]                 cur_list,
  output logic [5:0]                 cur_step,
  output logic                       list_aborted,
  output logic                       batt_done
);
  import lls_pkg::*;

  typedef enum logic [3:0]
  {
    LLS_IDLE = 4'b0001,
    LLS_LOAD = 4'b0010,
    LLS_RUN  = 4'b0100,
    LLS_GAP  = 4'b1000
  } lls_seq_t;

  lls_step_t   steps_r [`LLS_NUM_LISTS][`LLS_NUM_STEPS];
  lls_list_t   lists_r [`LLS_NUM_LISTS];
  lls_seq_t    seq_r;
  lls_step_t   step_r;
  logic [33:0] tick_cnt_r;
  logic [7:0]  div_r;
  logic        tick;
  logic [15:0] cyc_done_r;
  logic        ext_d_r;
  logic        trig_ok;
  logic        latched_r;
  logic        gate_on;
  logic        abort_now;
  logic [5:0]  nxt_idx;
  logic        last_step;

  // map an out-of-range list number to list 0, used by start and chain paths
  function automatic logic [2:0] lls_list_idx(input logic [2:0] l);
    lls_list_idx = (l >= 3'(`LLS_NUM_LISTS)) ? 3'h0 : l;
  endfunction

  // storage writes; out-of-range list or step indices are dropped
  always_ff @(posedge core_clk)
  begin
    if (step_wr.wr && step_wr.list < 3'(`LLS_NUM_LISTS) &&
        step_wr.index < 6'(`LLS_NUM_STEPS))
    begin
      steps_r[step_wr.list][step_wr.index] <= step_wr.step;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < `LLS_NUM_LISTS; i++)
      begin
        lists_r[i] <= '0;
      end
    end
    else if (list_wr && list_wr_sel < 3'(`LLS_NUM_LISTS))
    begin
      lists_r[list_wr_sel] <= list_wr_data;
    end
  end

  // 10 us tick divider
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || tick)
    begin
      div_r <= 8'h00;
    end
    else
    begin
      div_r <= div_r + 8'h01;
    end
  end
  assign tick = (div_r == 8'(`LLS_TICK_CYC - 1));

  // trigger source is only ever written by the remote path
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      trig_src <= LLS_SRC_EXT;
    end
    else if (src_wr && remote_ctl)
    begin
      trig_src <= src_wr_val;
    end
  end

  // falling-edge detect on the external pin
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ext_d_r <= 1'b1;
    end
    else
    begin
      ext_d_r <= ext_trig_in;
    end
  end

  // source qualification; immediate command always passes
  always_comb
  begin
    trig_ok = trig_imm_cmd;
    unique case (trig_src)
      LLS_SRC_BUS:  trig_ok = trig_ok | bus_get | bus_trg_cmd;
      LLS_SRC_EXT:  trig_ok = trig_ok | (ext_d_r & ~ext_trig_in) | key_trig;
      LLS_SRC_HOLD: trig_ok = trig_ok;
      default:      trig_ok = trig_ok;
    endcase
  end

  // operation select; local requests refused while input is on
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      op_active <= LLS_OP_BASIC;
    end
    else if (op_req && (remote_ctl || !input_on))
    begin
      op_active <= op_req_val;
    end
    else if (op_active == LLS_OP_BATTERY && batt_at_cutoff && input_on)
    begin
      op_active <= LLS_OP_BASIC;
    end
  end

  // immediate levels; presets copied on each accepted trigger
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      imm_cc <= `LLS_ZERO_LEVEL;
      imm_cv <= `LLS_ZERO_LEVEL;
      imm_cr <= `LLS_ZERO_LEVEL;
    end
    else if (trig_ok)
    begin
      imm_cc <= preset_cc;
      imm_cv <= preset_cv;
      imm_cr <= preset_cr;
    end
  end

  // transient toggle and pulse firing
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      tran_high  <= 1'b0;
      pulse_fire <= 1'b0;
    end
    else
    begin
      pulse_fire <= 1'b0;
      if (trig_ok && op_active == LLS_OP_TRAN)
      begin
        if (tran_mode == LLS_TRAN_TOGGLE)
        begin
          tran_high <= ~tran_high;
        end
        else if (tran_mode == LLS_TRAN_PULSE && !pulse_busy)
        begin
          pulse_fire <= 1'b1;
        end
      end
    end
  end

  // user input state and turn-on threshold gating
  assign gate_on = input_on && (von_ok || (von_latch_en && latched_r));
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      input_on  <= 1'b0;
      latched_r <= 1'b0;
    end
    else
    begin
      if (input_off_cmd || (op_active == LLS_OP_BATTERY && batt_at_cutoff))
      begin
        input_on <= 1'b0;
      end
      else if (input_on_cmd)
      begin
        input_on <= 1'b1;
      end
      if (!input_on)
      begin
        latched_r <= 1'b0;
      end
      else if (von_ok)
      begin
        latched_r <= 1'b1;
      end
    end
  end

  // list abort when the input is dropped by threshold or limit
  assign abort_now = (seq_r == LLS_RUN) && (curr_limit_trip || (input_on && !gate_on));
  assign nxt_idx   = cur_step + `LLS_ONE_STEP;
  assign last_step = (nxt_idx >= lists_r[cur_list].length);

  // list sequencer
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      seq_r        <= LLS_IDLE;
      cur_list     <= 3'h0;
      cur_step     <= 6'h00;
      step_r       <= '0;
      tick_cnt_r   <= '0;
      cyc_done_r   <= 16'h0000;
      list_aborted <= 1'b0;
    end
    else
    begin
      if (trig_ok && op_active == LLS_OP_LIST)
      begin
        list_aborted <= 1'b0;
      end
      unique case (seq_r)
        LLS_IDLE:
        begin
          if (trig_ok && op_active == LLS_OP_LIST)
          begin
            cur_list   <= lls_list_idx(list_select);
            cur_step   <= 6'h00;
            cyc_done_r <= 16'h0000;
            seq_r      <= LLS_LOAD;
          end
        end
        LLS_LOAD:
        begin
          step_r     <= steps_r[cur_list][cur_step];
          tick_cnt_r <= (steps_r[cur_list][cur_step].ticks < `LLS_STEP_MIN_TICKS) ?
                        `LLS_STEP_MIN_TICKS : steps_r[cur_list][cur_step].ticks;
          seq_r      <= LLS_RUN;
        end
        LLS_RUN:
        begin
          if (abort_now || op_active != LLS_OP_LIST)
          begin
            list_aborted <= abort_now;
            seq_r        <= LLS_IDLE;
          end
          else if (tick && tick_cnt_r <= `LLS_STEP_MIN_TICKS)
          begin
            // next step selection, with cycle repeat and chaining
            if (!last_step)
            begin
              cur_step <= nxt_idx;
            end
            else if (cyc_done_r + 16'h0001 < lists_r[cur_list].cycles)
            begin
              cur_step   <= 6'h00;
              cyc_done_r <= cyc_done_r + 16'h0001;
            end
            else if (lists_r[cur_list].chain_en)
            begin
              cur_list   <= lls_list_idx(lists_r[cur_list].chain_to);
              cur_step   <= 6'h00;
              cyc_done_r <= 16'h0000;
            end
            else
            begin
              seq_r <= LLS_IDLE;
            end
            if (!last_step || cyc_done_r + 16'h0001 < lists_r[cur_list].cycles ||
                lists_r[cur_list].chain_en)
            begin
              // mode of the following step decides whether a gap is needed
              if (steps_r[last_step ? (lists_r[cur_list].chain_en &&
                  !(cyc_done_r + 16'h0001 < lists_r[cur_list].cycles) ?
                  lls_list_idx(lists_r[cur_list].chain_to) : cur_list) : cur_list]
                  [last_step ? 6'h00 : nxt_idx].mode != step_r.mode)
              begin
                tick_cnt_r <= 34'(`LLS_GAP_TICKS);
                seq_r      <= LLS_GAP;
              end
              else
              begin
                seq_r <= LLS_LOAD;
              end
            end
          end
          else if (tick)
          begin
            tick_cnt_r <= tick_cnt_r - 34'h1;
          end
        end
        LLS_GAP:
        begin
          if (op_active != LLS_OP_LIST)
          begin
            seq_r <= LLS_IDLE;
          end
          else if (tick && tick_cnt_r <= `LLS_STEP_MIN_TICKS)
          begin
            seq_r <= LLS_LOAD;
          end
          else if (tick)
          begin
            tick_cnt_r <= tick_cnt_r - 34'h1;
          end
        end
      endcase
    end
  end

  assign list_running = (seq_r != LLS_IDLE);
  assign list_in_gap  = (seq_r == LLS_GAP);

  // regulation output; short flag changes neither value nor stored settings
  always_comb
  begin
    reg_mode = basic_mode;
    if (op_active == LLS_OP_LIST && list_running)
    begin
      reg_mode = step_r.mode;
    end
    else if (op_active == LLS_OP_BATTERY)
    begin
      reg_mode = LLS_MODE_CC;
    end
    if (reg_mode == LLS_MODE_CV && cv_cap_reached)
    begin
      reg_mode = LLS_MODE_CC;
    end
  end

  assign short_active = short_en && conduct;
  assign conduct      = gate_on && !list_in_gap && !curr_limit_trip;

  // value per active mode; zero when not conducting
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || !conduct)
    begin
      reg_value <= `LLS_ZERO_LEVEL;
    end
    else if (op_active == LLS_OP_LIST && list_running)
    begin
      reg_value <= step_r.value;
    end
    else
    begin
      unique case (reg_mode)
        LLS_MODE_CV: reg_value <= imm_cv;
        LLS_MODE_CR: reg_value <= imm_cr;
        default:     reg_value <= imm_cc;
      endcase
    end
  end

  assign batt_done = (op_active == LLS_OP_BATTERY) && batt_at_cutoff;
endmodule
`default_nettype wire

// [testbench/lls_trig_host.sv]
`timescale 1ns/10ps
`default_nettype none
// far side: bus controller commands and the external trigger pin
module lls_trig_host
(
  input  wire logic core_clk,
  output logic      bus_get,
  output logic      bus_trg_cmd,
  output logic      trig_imm_cmd,
  output logic      ext_trig_in,
  output logic      key_trig
);
  // strobes idle low; the pin idles high like a pulled-up ttl line
  initial
  begin
    {bus_get, bus_trg_cmd, trig_imm_cmd, key_trig} = 4'h0;
    ext_trig_in = 1'b1;
  end

  // one command per call, held for one edge; the pin is low two edges
  task automatic send(input logic [2:0] kind);
    @(posedge core_clk);
    #2;
    case (kind)
      3'h0: bus_get = 1'b1;
      3'h1: bus_trg_cmd = 1'b1;
      3'h2: trig_imm_cmd = 1'b1;
      3'h3: ext_trig_in = 1'b0;
      default: key_trig = 1'b1;
    endcase
    @(posedge core_clk);
    #2;
    {bus_get, bus_trg_cmd, trig_imm_cmd, key_trig} = 4'h0;
    @(posedge core_clk);
    #2;
    ext_trig_in = 1'b1;
  endtask
endmodule
`default_nettype wire

// [testbench/lls_sequencer_props.sv]
`timescale 1ns/10ps
`default_nettype none
module lls_sequencer_props
(
  input wire logic               core_clk,
  input wire logic               reset_n,
  input wire logic               remote_ctl,
  input wire logic               op_req,
  input wire logic               src_wr,
  input wire logic               bus_get,
  input wire logic               trig_imm_cmd,
  input wire logic               pulse_busy,
  input wire logic [15:0]        preset_cc,
  input wire logic               input_on_cmd,
  input wire logic               von_ok,
  input wire logic               von_latch_en,
  input wire logic               cv_cap_reached,
  input wire logic               batt_at_cutoff,
  input wire lls_pkg::lls_mode_t basic_mode,
  input wire lls_pkg::lls_tran_t tran_mode,
  input wire lls_pkg::lls_op_t   op_active,
  input wire lls_pkg::lls_src_t  trig_src,
  input wire lls_pkg::lls_mode_t reg_mode,
  input wire logic [15:0]        imm_cc,
  input wire logic               conduct,
  input wire logic               input_on,
  input wire logic               pulse_fire,
  input wire logic               list_in_gap
);
  import lls_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // an accepted bus trigger while the pulse generator rests low
  sequence bus_pulse_s;
    trig_src == LLS_SRC_BUS && op_active == LLS_OP_TRAN && tran_mode == LLS_TRAN_PULSE
      && input_on && !pulse_busy && bus_get;
  endsequence

  // two edges in a row at the cap, so a registered fallback is also fair
  sequence cv_capped_s;
    (op_active == LLS_OP_BASIC && basic_mode == LLS_MODE_CV && input_on
      && cv_cap_reached)[*2];
  endsequence

  off_no_conduct_a: assert property (!input_on |-> !conduct)
    else $error("conducting with input off");
  von_gate_a: assert property (!von_ok && !von_latch_en |-> !conduct)
    else $error("conducting below turn-on threshold");
  gap_off_a: assert property (list_in_gap |-> !conduct)
    else $error("conducting inside mode gap");
  src_local_a: assert property (src_wr && !remote_ctl |=> $stable(trig_src))
    else $error("source changed under local control");
  op_local_a: assert property (op_req && !remote_ctl && input_on && !batt_at_cutoff
    |=> $stable(op_active))
    else $error("operation changed locally with input on");
  imm_copy_a: assert property (trig_imm_cmd |=> imm_cc == $past(preset_cc))
    else $error("immediate trigger did not copy preset");
  hold_src_a: assert property (trig_src == LLS_SRC_HOLD && !trig_imm_cmd
    |=> $stable(imm_cc))
    else $error("hold source took another trigger");
  busy_ignore_a: assert property (pulse_busy |=> !pulse_fire)
    else $error("pulse fired while busy");
  bus_pulse_a: assert property (bus_pulse_s |=> pulse_fire)
    else $error("bus trigger gave no pulse");
  batt_stop_a: assert property (op_active == LLS_OP_BATTERY && input_on
    && batt_at_cutoff && !input_on_cmd |=> !input_on)
    else $error("discharge kept running at cut-off");
  cv_fallback_a: assert property (cv_capped_s |-> reg_mode == LLS_MODE_CC && input_on)
    else $error("no current fallback at cap");
endmodule

bind lls_sequencer lls_sequencer_props u_lls_sequencer_props
(
  .core_clk(core_clk), .reset_n(reset_n), .remote_ctl(remote_ctl), .op_req(op_req),
  .src_wr(src_wr), .bus_get(bus_get), .trig_imm_cmd(trig_imm_cmd), .pulse_busy(pulse_busy),
  .preset_cc(preset_cc), .input_on_cmd(input_on_cmd), .von_ok(von_ok),
  .von_latch_en(von_latch_en), .cv_cap_reached(cv_cap_reached),
  .batt_at_cutoff(batt_at_cutoff), .basic_mode(basic_mode), .tran_mode(tran_mode),
  .op_active(op_active), .trig_src(trig_src), .reg_mode(reg_mode), .imm_cc(imm_cc),
  .conduct(conduct), .input_on(input_on), .pulse_fire(pulse_fire),
  .list_in_gap(list_in_gap)
);
`default_nettype wire

// [testbench/tb_lls_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    check_count++; \
    if ((gt) !== (ex)) \
    begin \
      mismatches++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module tb_lls_sequencer;
  import lls_pkg::*;
  typedef struct packed
  {
    lls_src_t   src;
    logic [2:0] kind;
    logic       hit;
  } lls_row_t;

  logic         core_clk, reset_n, list_wr, remote_ctl, op_req, src_wr, pulse_busy;
  logic         input_on_cmd, input_off_cmd, von_ok, von_latch_en, curr_limit_trip;
  logic         cv_cap_reached, batt_at_cutoff, short_en, short_active, batt_done;
  logic         bus_get, bus_trg_cmd, trig_imm_cmd, ext_trig_in, key_trig;
  logic         conduct, input_on, tran_high, pulse_fire, list_running, list_in_gap;
  logic         list_aborted;
  logic [2:0]   list_wr_sel, list_select, cur_list;
  logic [5:0]   cur_step;
  logic [15:0]  preset_cc, preset_cv, preset_cr, reg_value, imm_cc, imm_cv, imm_cr, exp_cc;
  lls_step_wr_t step_wr;
  lls_list_t    list_wr_data;
  lls_op_t      op_req_val, op_active;
  lls_mode_t    basic_mode, reg_mode;
  lls_tran_t    tran_mode;
  lls_src_t     src_wr_val, trig_src;
  int           mismatches, check_count, fires, t;
  lls_row_t     rows [15];

  lls_sequencer u_lls_sequencer
  (
    .core_clk, .reset_n, .step_wr, .list_wr, .list_wr_sel, .list_wr_data, .list_select,
    .remote_ctl, .op_req, .op_req_val, .basic_mode, .tran_mode, .src_wr, .src_wr_val,
    .bus_get, .bus_trg_cmd, .trig_imm_cmd, .ext_trig_in, .key_trig, .pulse_busy,
    .preset_cc, .preset_cv, .preset_cr, .input_on_cmd, .input_off_cmd, .von_ok,
    .von_latch_en, .curr_limit_trip, .cv_cap_reached, .batt_at_cutoff, .short_en,
    .op_active, .trig_src, .reg_mode, .reg_value, .imm_cc, .imm_cv, .imm_cr, .short_active,
    .conduct, .input_on, .tran_high, .pulse_fire, .list_running, .list_in_gap, .cur_list,
    .cur_step, .list_aborted, .batt_done
  );

  lls_trig_host u_lls_trig_host
  (
    .core_clk, .bus_get, .bus_trg_cmd, .trig_imm_cmd, .ext_trig_in, .key_trig
  );

  // 20 mhz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // count strobes here so a one-cycle pulse is never missed between checks
  always @(posedge core_clk)
    if (pulse_fire === 1'b1)
      fires++;

  // inputs always move 2 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic set_src(input lls_src_t s);
    src_wr_val = s;
    src_wr = 1'b1;
    tick(1);
    src_wr = 1'b0;
    tick(1);
  endtask

  task automatic set_op(input lls_op_t o);
    op_req_val = o;
    op_req = 1'b1;
    tick(1);
    op_req = 1'b0;
    tick(1);
  endtask

  task automatic power(input logic on);
    input_on_cmd = on;
    input_off_cmd = !on;
    tick(1);
    input_on_cmd = 1'b0;
    input_off_cmd = 1'b0;
    tick(1);
  endtask

  task automatic fire(input logic [2:0] k);
    u_lls_trig_host.send(k);
    tick(3);
  endtask

  task automatic wr_step(input logic [2:0] l, input logic [5:0] i, input lls_mode_t m,
                         input logic [33:0] tk);
    step_wr = '{1'b1, l, i, '{m, 16'h0011 + {14'h0, m}, tk}};
    tick(1);
    step_wr.wr = 1'b0;
    tick(1);
  endtask

  task automatic wr_list(input logic [2:0] l, input logic [15:0] c, input logic ce,
                         input logic [2:0] ct, input logic [5:0] len);
    list_wr_sel = l;
    list_wr_data = '{len, c, ce, ct};
    list_wr = 1'b1;
    tick(1);
    list_wr = 1'b0;
    tick(1);
  endtask

  task automatic end_test(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // the whole sequence needs well under 10000 cycles
  initial
  begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    test_done();
  end

  initial
  begin
    {reset_n, list_wr, remote_ctl, op_req, src_wr, pulse_busy, input_on_cmd} = 7'h00;
    {input_off_cmd, von_ok, von_latch_en, curr_limit_trip} = 4'h0;
    {cv_cap_reached, batt_at_cutoff, short_en} = 3'h0;
    {list_wr_sel, list_select, preset_cc, preset_cv, preset_cr, exp_cc} = 'h0;
    step_wr = '0;
    list_wr_data = '0;
    op_req_val = LLS_OP_BASIC;
    basic_mode = LLS_MODE_CC;
    tran_mode = LLS_TRAN_CONT;
    src_wr_val = LLS_SRC_BUS;
    fires = 0;
    // source, trigger kind, copied or not
    rows = '{'{LLS_SRC_BUS, 3'h0, 1'b1}, '{LLS_SRC_BUS, 3'h1, 1'b1}, '{LLS_SRC_BUS, 3'h2, 1'b1},
             '{LLS_SRC_BUS, 3'h3, 1'b0}, '{LLS_SRC_BUS, 3'h4, 1'b0}, '{LLS_SRC_EXT, 3'h0, 1'b0},
             '{LLS_SRC_EXT, 3'h1, 1'b0}, '{LLS_SRC_EXT, 3'h2, 1'b1}, '{LLS_SRC_EXT, 3'h3, 1'b1},
             '{LLS_SRC_EXT, 3'h4, 1'b1}, '{LLS_SRC_HOLD, 3'h0, 1'b0}, '{LLS_SRC_HOLD, 3'h1, 1'b0},
             '{LLS_SRC_HOLD, 3'h2, 1'b1}, '{LLS_SRC_HOLD, 3'h3, 1'b0}, '{LLS_SRC_HOLD, 3'h4, 1'b0}};
    tick(4);
    reset_n = 1'b1;
    tick(1);
    `CHK("op_active", LLS_OP_BASIC, op_active);
    `CHK("trig_src", LLS_SRC_EXT, trig_src);
    `CHK("imm_cc", 16'h0000, imm_cc);
    end_test("reset");
    remote_ctl = 1'b1;
    foreach (rows[i])
    begin
      set_src(rows[i].src);
      preset_cc = 16'h0100 + 16'(i);
      preset_cv = ~preset_cc;
      preset_cr = preset_cc ^ 16'h00ff;
      fire(rows[i].kind);
      if (rows[i].hit)
        exp_cc = preset_cc;
      `CHK("trig_src", rows[i].src, trig_src);
      `CHK("imm_cc", exp_cc, imm_cc);
      `CHK("imm_cv", ~exp_cc, imm_cv);
    end
    end_test("trigger sources");
    remote_ctl = 1'b0;
    set_src(LLS_SRC_BUS);
    `CHK("trig_src", LLS_SRC_HOLD, trig_src);
    power(1'b1);
    `CHK("conduct", 1'b0, conduct);
    von_ok = 1'b1;
    tick(2);
    `CHK("conduct", 1'b1, conduct);
    von_ok = 1'b0;
    tick(2);
    `CHK("conduct", 1'b0, conduct);
    von_latch_en = 1'b1;
    von_ok = 1'b1;
    tick(2);
    von_ok = 1'b0;
    tick(2);
    `CHK("conduct", 1'b1, conduct);
    set_op(LLS_OP_TRAN);
    `CHK("op_active", LLS_OP_BASIC, op_active);
    power(1'b0);
    `CHK("input_on", 1'b0, input_on);
    `CHK("imm_cc", exp_cc, imm_cc);
    set_op(LLS_OP_TRAN);
    `CHK("op_active", LLS_OP_TRAN, op_active);
    end_test("input control");
    {von_latch_en, von_ok, remote_ctl} = 3'h3;
    set_src(LLS_SRC_BUS);
    tran_mode = LLS_TRAN_TOGGLE;
    power(1'b1);
    fire(3'h0);
    `CHK("tran_high", 1'b1, tran_high);
    fire(3'h1);
    `CHK("tran_high", 1'b0, tran_high);
    tran_mode = LLS_TRAN_PULSE;
    t = fires;
    fire(3'h0);
    `CHK("fires", t + 1, fires);
    pulse_busy = 1'b1;
    fire(3'h0);
    `CHK("fires", t + 1, fires);
    pulse_busy = 1'b0;
    end_test("transient");
    power(1'b0);
    set_op(LLS_OP_BASIC);
    basic_mode = LLS_MODE_CV;
    power(1'b1);
    cv_cap_reached = 1'b1;
    short_en = 1'b1;
    tick(2);
    `CHK("reg_mode", LLS_MODE_CC, reg_mode);
    `CHK("reg_value", preset_cc, reg_value);
    `CHK("short_active", 1'b1, short_active);
    `CHK("input_on", 1'b1, input_on);
    cv_cap_reached = 1'b0;
    power(1'b0);
    basic_mode = LLS_MODE_CC;
    set_op(LLS_OP_BATTERY);
    power(1'b1);
    batt_at_cutoff = 1'b1;
    #1 `CHK("batt_done", 1'b1, batt_done);
    tick(2);
    `CHK("input_on", 1'b0, input_on);
    batt_at_cutoff = 1'b0;
    end_test("cap and battery");
    wr_step(3'h3, 6'h00, LLS_MODE_CC, 34'h2);
    wr_step(3'h4, 6'h00, LLS_MODE_CC, 34'h1);
    wr_list(3'h3, 16'h0002, 1'b1, 3'h4, 6'h01);
    wr_list(3'h4, 16'h0001, 1'b0, 3'h0, 6'h01);
    list_select = 3'h3;
    set_op(LLS_OP_LIST);
    power(1'b1);
    u_lls_trig_host.send(3'h2);
    t = 0;
    while (cur_list !== 3'h4 && t < 3000)
    begin
      tick(1);
      t++;
    end
    `CHK("cur_list", 3'h4, cur_list);
    `CHK("two runs", 1'b1, t > 500);
    while (list_running !== 1'b0 && t < 4000)
    begin
      tick(1);
      t++;
    end
    `CHK("list_running", 1'b0, list_running);
    end_test("cycles and chain");
    wr_step(3'h2, 6'h00, LLS_MODE_CC, 34'h1);
    wr_step(3'h2, 6'h01, LLS_MODE_CV, 34'h1);
    wr_list(3'h2, 16'h0001, 1'b0, 3'h0, 6'h02);
    list_select = 3'h2;
    fire(3'h2);
    `CHK("list_running", 1'b1, list_running);
    `CHK("cur_list", 3'h2, cur_list);
    `CHK("reg_mode", LLS_MODE_CC, reg_mode);
    t = 0;
    while (list_in_gap !== 1'b1 && t < 1000)
    begin
      tick(1);
      t++;
    end
    `CHK("list_in_gap", 1'b1, list_in_gap);
    `CHK("conduct", 1'b0, conduct);
    `CHK("cur_step", 6'h01, cur_step);
    set_op(LLS_OP_BASIC);
    set_op(LLS_OP_LIST);
    curr_limit_trip = 1'b1;
    fire(3'h2);
    `CHK("list_aborted", 1'b1, list_aborted);
    `CHK("list_running", 1'b0, list_running);
    end_test("gap and abort");
    test_done();
  end
endmodule
`default_nettype wire
